// ===== rtl/monitor_flag_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_flag_sampler
    import vmon_status_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] raw_a_in,
    input  wire logic [7:0] raw_b_in,
    monitor_flags_if.source flags
);
    logic [7:0] status_a_reg;
    logic [7:0] status_b_reg;

    // flags track comparators each cycle, no latching
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            status_a_reg <= STATUS_A_RESET;
        end else begin
            status_a_reg <= raw_a_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            status_b_reg <= STATUS_B_RESET;
        end else begin
            status_b_reg <= raw_b_in;
        end
    end

    assign flags.status_a = status_a_reg;
    assign flags.status_b = status_b_reg;
endmodule
`default_nettype wire

// ===== rtl/monitor_flags_if.sv
`timescale 1ns/1ps
`default_nettype none
interface monitor_flags_if;
    logic [7:0] status_a;
    logic [7:0] status_b;
    modport source (output status_a, output status_b);
    modport sink   (input status_a, input status_b);
endinterface
`default_nettype wire

// ===== rtl/vmon_status_pkg.sv
package vmon_status_pkg;

    localparam int          STATUS_WIDTH = 8;

    // read and write command codes on the controller port
    localparam logic [7:0]  CMD_READ_STATUS_A = 8'h01;
    localparam logic [7:0]  CMD_READ_STATUS_B = 8'h02;
    localparam logic [7:0]  CMD_WRITE_STATUS_A = 8'h81;
    localparam logic [7:0]  CMD_WRITE_STATUS_B = 8'h82;

    localparam logic [7:0]  STATUS_A_RESET = 8'h00;
    localparam logic [7:0]  STATUS_B_RESET = 8'h00;
    localparam logic [7:0]  READ_IDLE_DATA = 8'h00;

    // status a field positions
    localparam int          A_REF_HIGH_BIT    = 0;
    localparam int          A_REF_LOW_BIT     = 1;
    localparam int          A_MON_SUPPLY_BIT  = 2;
    localparam int          A_PUMP_LOW_BIT    = 3;

    // status b field positions
    localparam int          B_CORE_LOW_BIT    = 0;
    localparam int          B_CORE_HIGH_BIT   = 1;
    localparam int          B_IO_LOW_BIT      = 2;
    localparam int          B_IO_HIGH_BIT     = 3;
    localparam int          B_FIVE_LOW_BIT    = 4;
    localparam int          B_FIVE_HIGH_BIT   = 5;
    localparam int          B_PREREG_LOW_BIT  = 6;
    localparam int          B_PREREG_HIGH_BIT = 7;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DONE = 2'b10
    } read_state_type;

endpackage

// ===== rtl/voltage_monitor_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module voltage_monitor_status_regs
    import vmon_status_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       reference_high_error_in,
    input  wire logic       reference_low_error_in,
    input  wire logic       monitor_supply_bad_flag_in,
    input  wire logic       charge_pump_low_flag_in,
    input  wire logic [3:0] status_a_upper_in,
    input  wire logic       prereg_rail_high_flag_in,
    input  wire logic       prereg_rail_low_flag_in,
    input  wire logic       five_volt_rail_high_flag_in,
    input  wire logic       five_volt_rail_low_flag_in,
    input  wire logic       io_rail_high_flag_in,
    input  wire logic       io_rail_low_flag_in,
    input  wire logic       core_rail_high_flag_in,
    input  wire logic       core_rail_low_flag_in,
    input  wire logic       cmd_valid_in,
    input  wire logic [7:0] cmd_code_in,
    output logic [7:0]      read_data_out,
    output logic            read_valid_out,
    output logic [7:0]      supply_monitor_status_a_out,
    output logic [7:0]      rail_monitor_status_b_out
);
    localparam int RAIL_COUNT     = STATUS_WIDTH / 2;
    localparam int A_SOURCE_COUNT = 4;

    // field positions per rail, index 0 is the core rail
    localparam int RAIL_HIGH_POS [RAIL_COUNT] = '{
        B_CORE_HIGH_BIT,
        B_IO_HIGH_BIT,
        B_FIVE_HIGH_BIT,
        B_PREREG_HIGH_BIT
    };
    localparam int RAIL_LOW_POS [RAIL_COUNT] = '{
        B_CORE_LOW_BIT,
        B_IO_LOW_BIT,
        B_FIVE_LOW_BIT,
        B_PREREG_LOW_BIT
    };
    localparam int A_SOURCE_POS [A_SOURCE_COUNT] = '{
        A_REF_HIGH_BIT,
        A_REF_LOW_BIT,
        A_MON_SUPPLY_BIT,
        A_PUMP_LOW_BIT
    };

    wire logic [RAIL_COUNT-1:0]     rail_high;
    wire logic [RAIL_COUNT-1:0]     rail_low;
    wire logic [A_SOURCE_COUNT-1:0] a_source;
    wire logic [7:0]                raw_a;
    wire logic [7:0]                raw_b;
    logic                           read_a_req;
    logic                           read_b_req;
    logic                           read_req;
    logic                           ignored_req;
    logic [7:0]                     read_data_reg;
    logic [7:0]                     read_data_next;
    logic                           read_valid;
    read_state_type                 state_reg;
    read_state_type                 state_next;

    monitor_flags_if flags_bus ();

    // other status a monitors live outside this block
    assign raw_a[7:4] = status_a_upper_in;

    assign a_source[0] = reference_high_error_in;
    assign a_source[1] = reference_low_error_in;
    assign a_source[2] = monitor_supply_bad_flag_in;
    assign a_source[3] = charge_pump_low_flag_in;

    for (genvar s = 0; s < A_SOURCE_COUNT; s++) begin : g_a_pack
        assign raw_a[A_SOURCE_POS[s]] = a_source[s];
    end

    assign rail_high[3] = prereg_rail_high_flag_in;
    assign rail_low[3]  = prereg_rail_low_flag_in;
    assign rail_high[2] = five_volt_rail_high_flag_in;
    assign rail_low[2]  = five_volt_rail_low_flag_in;
    assign rail_high[1] = io_rail_high_flag_in;
    assign rail_low[1]  = io_rail_low_flag_in;
    assign rail_high[0] = core_rail_high_flag_in;
    assign rail_low[0]  = core_rail_low_flag_in;

    // each rail owns one high/low pair, the msb pair is the prereg rail
    for (genvar r = 0; r < RAIL_COUNT; r++) begin : g_rail_pack
        assign raw_b[RAIL_HIGH_POS[r]] = rail_high[r];
        assign raw_b[RAIL_LOW_POS[r]]  = rail_low[r];
    end

    // one cycle of latency, flags are never held past their condition
    monitor_flag_sampler sampler (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .raw_a_in (raw_a),
        .raw_b_in (raw_b),
        .flags    (flags_bus.source)
    );

    // only the two read codes get an answer
    always_comb begin
        read_a_req  = 1'b0;
        read_b_req  = 1'b0;
        ignored_req = 1'b0;
        if (cmd_valid_in) begin
            case (cmd_code_in)
                CMD_READ_STATUS_A: begin
                    read_a_req = 1'b1;
                end
                CMD_READ_STATUS_B: begin
                    read_b_req = 1'b1;
                end
                CMD_WRITE_STATUS_A: begin
                    // flags follow the monitors only, a write has nowhere to land
                    ignored_req = 1'b1;
                end
                CMD_WRITE_STATUS_B: begin
                    ignored_req = 1'b1;
                end
                default: begin
                    // unknown codes are dropped the same way
                    ignored_req = 1'b1;
                end
            endcase
        end
    end

    assign read_req = read_a_req || read_b_req;

    // back to back reads hold the machine in the done state
    always_comb begin
        state_next = RD_IDLE;
        case (state_reg)
            RD_IDLE: begin
                if (ignored_req) begin
                    state_next = RD_IDLE;
                end else if (read_req) begin
                    state_next = RD_DONE;
                end else begin
                    state_next = RD_IDLE;
                end
            end
            RD_DONE: begin
                if (ignored_req) begin
                    state_next = RD_IDLE;
                end else if (read_req) begin
                    state_next = RD_DONE;
                end else begin
                    state_next = RD_IDLE;
                end
            end
            default: begin
                state_next = RD_IDLE;
            end
        endcase
    end

    // read data is the register value from before the command edge
    always_comb begin
        read_data_next = READ_IDLE_DATA;
        if (read_a_req) begin
            read_data_next = flags_bus.status_a;
        end else if (read_b_req) begin
            read_data_next = flags_bus.status_b;
        end else if (ignored_req) begin
            read_data_next = READ_IDLE_DATA;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= RD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            read_data_reg <= READ_IDLE_DATA;
        end else begin
            read_data_reg <= read_data_next;
        end
    end

    // answer stands exactly one cycle per accepted read
    always_comb begin
        case (state_reg)
            RD_IDLE: begin
                read_valid = 1'b0;
            end
            RD_DONE: begin
                read_valid = 1'b1;
            end
            default: begin
                read_valid = 1'b0;
            end
        endcase
    end

    assign read_data_out               = read_data_reg;
    assign read_valid_out              = read_valid;
    assign supply_monitor_status_a_out = flags_bus.status_a;
    assign rail_monitor_status_b_out   = flags_bus.status_b;
endmodule
`default_nettype wire

// ===== verification/vmon_status_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vmon_status_checker
    import vmon_status_pkg::*;
(
    input wire logic       clock_in,
    input wire logic       rst_in,
    input wire logic       reference_high_error_in,
    input wire logic       reference_low_error_in,
    input wire logic       prereg_rail_low_flag_in,
    input wire logic       five_volt_rail_high_flag_in,
    input wire logic       io_rail_low_flag_in,
    input wire logic       core_rail_low_flag_in,
    input wire logic       cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] read_data_out,
    input wire logic       read_valid_out,
    input wire logic [7:0] supply_monitor_status_a_out,
    input wire logic [7:0] rail_monitor_status_b_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic       live;
    wire  [7:0] sa = supply_monitor_status_a_out;
    wire  [7:0] sb = rail_monitor_status_b_out;
    // first edge after reset still sees reset-time inputs
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end
    property p_b6; live |-> sb[6] == $past(prereg_rail_low_flag_in); endproperty
    a_b6: assert property (p_b6) else $error("b6 wrong");
    property p_b5; live |-> sb[5] == $past(five_volt_rail_high_flag_in); endproperty
    a_b5: assert property (p_b5) else $error("b5 wrong");
    property p_b2; live |-> sb[2] == $past(io_rail_low_flag_in); endproperty
    a_b2: assert property (p_b2) else $error("b2 wrong");
    property p_b0; live |-> sb[0] == $past(core_rail_low_flag_in); endproperty
    a_b0: assert property (p_b0) else $error("b0 wrong");
    property p_a1; live |-> sa[1] == $past(reference_low_error_in); endproperty
    a_a1: assert property (p_a1) else $error("a1 wrong");
    property p_a0; (live && !reference_high_error_in) [*2] |-> !sa[0]; endproperty
    a_a0: assert property (p_a0) else $error("a0 stuck");
    property p_rdb; cmd_valid_in && cmd_code_in == CMD_READ_STATUS_B
        |=> read_valid_out && read_data_out == $past(sb); endproperty
    a_rdb: assert property (p_rdb) else $error("read b wrong");
    property p_rda; cmd_valid_in && cmd_code_in == CMD_READ_STATUS_A
        |=> read_valid_out && read_data_out == $past(sa); endproperty
    a_rda: assert property (p_rda) else $error("read a wrong");
    property p_wr; cmd_valid_in && cmd_code_in[7] |=> !read_valid_out; endproperty
    a_wr: assert property (p_wr) else $error("write answered");
    property p_idle; !read_valid_out |-> read_data_out == READ_IDLE_DATA; endproperty
    a_idle: assert property (p_idle) else $error("idle data wrong");
    c_rdb: cover property (cmd_valid_in && cmd_code_in == CMD_READ_STATUS_B);
    c_wr: cover property (cmd_valid_in && cmd_code_in == CMD_WRITE_STATUS_B);
    c_b6: cover property (live && sb[6]);
endmodule
bind voltage_monitor_status_regs vmon_status_checker chk (.*);
`default_nettype wire

// ===== verification/voltage_monitor_status_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module voltage_monitor_status_regs_tb_top;
    import vmon_status_pkg::*;
    logic       clock_in = 0, rst_in = 1, cmd_valid = 0, rd_valid;
    logic [7:0] a_raw = 0, b_raw = 0, code = 0, a2 = 0, b2 = 0, rd_data, st_a, st_b;
    int         n_mismatch = 0, samples_checked = 0, cycles = 0, seed = 32'hed095017;
    always #12.5 clock_in = ~clock_in;
    voltage_monitor_status_regs dut (.clock_in(clock_in), .rst_in(rst_in),
        .reference_high_error_in(a_raw[0]), .reference_low_error_in(a_raw[1]),
        .monitor_supply_bad_flag_in(a_raw[2]), .charge_pump_low_flag_in(a_raw[3]),
        .status_a_upper_in(a_raw[7:4]), .prereg_rail_high_flag_in(b_raw[7]),
        .prereg_rail_low_flag_in(b_raw[6]), .five_volt_rail_high_flag_in(b_raw[5]),
        .five_volt_rail_low_flag_in(b_raw[4]), .io_rail_high_flag_in(b_raw[3]),
        .io_rail_low_flag_in(b_raw[2]), .core_rail_high_flag_in(b_raw[1]),
        .core_rail_low_flag_in(b_raw[0]), .cmd_valid_in(cmd_valid), .cmd_code_in(code),
        .read_data_out(rd_data), .read_valid_out(rd_valid),
        .supply_monitor_status_a_out(st_a), .rail_monitor_status_b_out(st_b));
    function automatic logic [8:0] exp_read(logic v, logic [7:0] c, a, b);
        if (v && c == CMD_READ_STATUS_A) return {1'b1, a};
        if (v && c == CMD_READ_STATUS_B) return {1'b1, b};
        return {1'b0, READ_IDLE_DATA};
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clock_in) begin
        if (++cycles == 2000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(negedge clock_in);
        rst_in = 0;
        for (int i = 0; i < 400; i++) begin
            @(negedge clock_in);
            `CHK("status a", a_raw, st_a)
            `CHK("status b", b_raw, st_b)
            `CHK("read", exp_read(cmd_valid, code, a2, b2), {rd_valid, rd_data})
            a2 = a_raw;
            b2 = b_raw;
            // all set then all clear before random flags
            a_raw = (i < 2) ? {8{i == 0}} : 8'($random(seed));
            b_raw = (i < 2) ? {8{i == 0}} : 8'($random(seed));
            cmd_valid = 1'($random(seed));
            code = 8'($random(seed)) & 8'h83;
        end
        $display("random flag and command test done");
        rst_in = 1;
        @(negedge clock_in);
        `CHK("reset b", STATUS_B_RESET, st_b)
        `CHK("reset a", STATUS_A_RESET, st_a)
        `CHK("reset read", {1'b0, READ_IDLE_DATA}, {rd_valid, rd_data})
        $display("reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
